/* rtl/hbf_fault_reporter.sv */
// Fault supervision and reporting core of an integrated half-bridge stage
//
// What this block does
// [RL1] Report temperature at 8 mV/degC, 800 mV@25C
// [RL2] Any fault forces output to logic supply
// [RL3] Fault code appears fixed delay after fault
// [RL4] Codes: OC 10k down, OT 20k down, short 1k up
// [RL5] Eight consecutive limits trip over-current, latch high-side off
// [RL6] After OC/OT, low side on until zero current
// [RL7] Over-temperature latches fault, high side off, 20k
// [RL8] Switch node short latches fault, 1k pull-up
// [RL9] Enable toggle or supply cycle clears latch
// [RL10] Single limit event blanks high side this cycle
// [RL11] Negative valley limit never reports a fault
// [RL12] Clean switching cycle resets over-current count
// [RL13] First fault type stays until release
`timescale 1ns/100ps
`default_nettype none
module hbf_fault_reporter
  import hbf_pkg::*;
(
  input wire logic core_clk, // Clock, 50 MHz
  input wire logic resetn, // Async reset, active low (supply power-on)
  input wire logic enable_in, // Enable pin, asynchronous
  input wire logic supply_ok, // Logic supply above undervoltage_lockout, async
  input wire logic pwm_high, // Modulation input requests high side on, async
  input wire logic cycle_start, // Switching cycle boundary indication, async
  input wire logic hs_ilim, // High-side current limit comparator, async
  input wire logic ls_valley_lim, // Low-side negative valley limit, async
  input wire logic zero_current_detect, // Inductor current at zero, async
  input wire logic sw_short, // switch_node to power_ground short, async
  input wire logic signed [TEMP_W-1:0] tj_degc, // Junction temperature, degC
  output logic high_side_switch, // High-side gate enable
  output logic low_side_switch, // Low-side gate enable
  output logic [MV_W-1:0] temp_fault_mv, // temp_fault_output level in mV
  output logic temp_fault_at_supply, // temp_fault_output forced to logic supply
  output logic [1:0] pwm_term, // Termination code on modulation input
  output logic fault_latched // Any fault latched
);
  localparam int NS = 7; // Synchronised pins
  logic [NS-1:0] raw_in; // Pin bundle
  logic [NS-1:0] syn; // Synchronised bundle
  logic en_s, ok_s, pwm_s, cyc_s, ilim_s, valley_s, zcd_s; // Unused valley kept named
  logic en_d_r; // Enable delayed for edge detect
  logic cyc_d_r; // Cycle boundary delayed
  logic active; // Enabled and supply good
  logic release_ev; // Latch release event
  logic cyc_edge; // Rising edge of cycle boundary
  logic [OC_W-1:0] oc_cnt_r; // Consecutive limited-cycle count
  logic lim_seen_r; // Limit seen in current cycle
  logic oc_trip; // Over-current fault condition
  logic ot_trip; // Over-temperature condition
  logic short_trip; // Short condition
  logic any_trip; // Any new fault
  hbf_state_t state_r; // Supervision state
  hbf_term_t code_r; // Latched fault type
  logic [DLY_W-1:0] dly_r; // Code delay counter
  logic ls_hold_r; // Low side kept on until zero current
  logic signed [15:0] mv_calc; // Temperature in mV, wide
  logic short_s; // Synchronised short

  assign raw_in = {enable_in, supply_ok, pwm_high, cycle_start, hs_ilim, zero_current_detect,
                   sw_short};

  hbf_sync #(.W(NS)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .d(raw_in),
    .q(syn)
  );

  // Valley limit only steers the analog loop; it has no path into fault logic
  assign valley_s = 1'b0; // see [RL11]
  assign {en_s, ok_s, pwm_s, cyc_s, ilim_s, zcd_s, short_s} = syn;
  assign active = en_s && ok_s;
  // Either enable edge, or supply dropping, releases the latch
  assign release_ev = (en_s != en_d_r) || !ok_s; // see [RL9]
  assign cyc_edge = cyc_s && !cyc_d_r;
  assign oc_trip = cyc_edge && (lim_seen_r || ilim_s) && (oc_cnt_r == OC_TRIP - OC_ONE); // see [RL5]
  assign ot_trip = tj_degc > OT_THRESH_DEGC; // see [RL7]
  assign short_trip = short_s; // see [RL8]
  assign any_trip = active && (oc_trip || ot_trip || short_trip) && !valley_s;
  assign mv_calc = 16'(TEMP_OFS_MV) + 16'(TEMP_GAIN_MV) * (16'(tj_degc) - 16'(TEMP_OFS_DEGC));

  // Edge-detect history
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      en_d_r <= 1'b0;
      cyc_d_r <= 1'b0;
    end else begin
      en_d_r <= en_s;
      cyc_d_r <= cyc_s;
    end
  end

  // Per-cycle limit tracking and consecutive counter
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lim_seen_r <= 1'b0;
      oc_cnt_r <= OC_ZERO;
    end else if (release_ev || state_r != HBF_RUN) begin
      lim_seen_r <= 1'b0;
      oc_cnt_r <= OC_ZERO;
    end else if (cyc_edge) begin
      lim_seen_r <= 1'b0;
      if (lim_seen_r || ilim_s) begin
        oc_cnt_r <= oc_cnt_r + OC_ONE;
      end else begin
        oc_cnt_r <= OC_ZERO; // see [RL12]
      end
    end else if (ilim_s) begin
      lim_seen_r <= 1'b1;
    end
  end

  // Fault latch, type capture and code delay
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= HBF_RUN;
      code_r <= HBF_TERM_NONE;
      dly_r <= '0;
    end else if (release_ev) begin
      state_r <= HBF_RUN; // see [RL9]
      code_r <= HBF_TERM_NONE;
      dly_r <= '0;
    end else begin
      unique case (state_r)
        HBF_RUN: begin
          if (any_trip) begin
            state_r <= HBF_WAIT;
            dly_r <= '0;
            // Short has priority: it needs the strongest indication
            if (short_trip) begin
              code_r <= HBF_TERM_PU1K; // see [RL4]
            end else if (ot_trip) begin
              code_r <= HBF_TERM_PD20K; // see [RL4]
            end else begin
              code_r <= HBF_TERM_PD10K; // see [RL4]
            end
          end
        end
        HBF_WAIT: begin
          // Code type held; later faults ignored
          if (dly_r == DLY_LAST) begin
            state_r <= HBF_CODE; // see [RL3]
          end else begin
            dly_r <= dly_r + 4'h1;
          end
        end
        HBF_CODE: begin
          state_r <= HBF_CODE; // see [RL13]
        end
        default: begin
          state_r <= HBF_RUN;
        end
      endcase
    end
  end

  // Low-side hold after OC/OT until zero current; a short as the tripping fault turns it off at once
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ls_hold_r <= 1'b0;
    end else if (release_ev) begin
      ls_hold_r <= 1'b0;
    end else if (state_r == HBF_RUN && any_trip) begin
      ls_hold_r <= !short_trip && !zcd_s; // see [RL6]
    end else if (zcd_s) begin
      ls_hold_r <= 1'b0; // see [RL6]
    end
  end

  // Gate drive outputs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      high_side_switch <= 1'b0;
      low_side_switch <= 1'b0;
    end else if (!active) begin
      high_side_switch <= 1'b0;
      low_side_switch <= 1'b0;
    end else if (state_r == HBF_RUN && any_trip) begin
      // Hold taken from the trip itself, so the low side does not drop for a cycle
      high_side_switch <= 1'b0; // see [RL5]
      low_side_switch <= !short_trip && !zcd_s; // see [RL6]
    end else if (state_r != HBF_RUN) begin
      high_side_switch <= 1'b0; // see [RL5]
      low_side_switch <= ls_hold_r && !zcd_s; // see [RL6]
    end else begin
      // Limit blanks the high side for the rest of this cycle
      high_side_switch <= pwm_s && !ilim_s && !lim_seen_r; // see [RL10]
      low_side_switch <= !pwm_s;
    end
  end

  // Reporting outputs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      temp_fault_mv <= '0;
      temp_fault_at_supply <= 1'b0;
      pwm_term <= HBF_TERM_NONE;
      fault_latched <= 1'b0;
    end else begin
      fault_latched <= state_r != HBF_RUN;
      temp_fault_at_supply <= state_r != HBF_RUN; // see [RL2]
      pwm_term <= (state_r == HBF_CODE) ? code_r : HBF_TERM_NONE; // see [RL3]
      if (active && state_r == HBF_RUN) begin
        temp_fault_mv <= mv_calc[15] ? '0 : mv_calc[MV_W-1:0]; // see [RL1]
      end else begin
        temp_fault_mv <= '0;
      end
    end
  end
endmodule
`default_nettype wire

/* shared/hbf_pkg.sv */
// Constants and types for the half-bridge fault reporter
package hbf_pkg;
  // Clock rate
  localparam int CLK_PERIOD_NS = 20;
  // Fault indication delay in ns and in cycles (least time, rounded up)
  localparam int FAULT_CODE_DELAY_NS = 200;
  localparam int FAULT_CODE_DELAY_CYC = (FAULT_CODE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_W = 4;
  localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(FAULT_CODE_DELAY_CYC - 1);
  // Over-current trip after this many consecutive limited cycles
  localparam int OC_TRIP_COUNT = 8;
  localparam int OC_W = 4;
  localparam logic [OC_W-1:0] OC_TRIP = OC_W'(OC_TRIP_COUNT);
  localparam logic [OC_W-1:0] OC_ZERO = 4'h0;
  localparam logic [OC_W-1:0] OC_ONE = 4'h1;
  // Temperature report: 8 mV per degree, 800 mV at 25 degC
  localparam int TEMP_GAIN_MV = 8;
  localparam int TEMP_OFS_MV = 800;
  localparam int TEMP_OFS_DEGC = 25;
  localparam int TEMP_W = 9;
  localparam int MV_W = 12;
  localparam logic signed [TEMP_W-1:0] OT_THRESH_DEGC = 9'sh0A0;
  // Termination code on the modulation input
  typedef enum logic [1:0] {
    HBF_TERM_NONE = 2'h0, // Normal tri-state input termination
    HBF_TERM_PD10K = 2'h1, // 10k to analog_ground: over-current
    HBF_TERM_PD20K = 2'h2, // 20k to analog_ground: over-temperature
    HBF_TERM_PU1K = 2'h3 // 1k to logic supply: switch_node short
  } hbf_term_t;
  // Supervision states, Gray coded along the usual path
  typedef enum logic [1:0] {
    HBF_RUN = 2'h0, // Normal operation
    HBF_WAIT = 2'h1, // Fault latched, code delay running
    HBF_CODE = 2'h3 // Fault latched, code presented
  } hbf_state_t;
endpackage

/* rtl/hbf_sync.sv */
// Two flip-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module hbf_sync #(
  parameter int W = 1
) (
  input wire logic core_clk, // Clock
  input wire logic resetn, // Async reset, active low
  input wire logic [W-1:0] d, // Raw asynchronous inputs
  output logic [W-1:0] q // Synchronised outputs
);
  logic [W-1:0] meta_r; // First stage, read only by second

  // Each bit gets its own two-stage chain
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          meta_r[i] <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta_r[i] <= d[i];
          q[i] <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* verif/hbf_ctrl_model.sv */
// Controller-side model: switching cycles, modulation and enable
`timescale 1ns/100ps
`default_nettype none
module hbf_ctrl_model (
  input wire logic core_clk, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic slow, // Longer switching period
  input wire logic drop_en, // Hold enable low
  output logic enable_in, // Enable pin
  output logic pwm_high, // High side request
  output logic cycle_start // Cycle boundary pulse
);
  logic [4:0] ph_r; // Phase within the period
  // Period of 12 or 24 clocks, so quick and slow cycles are both seen
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ph_r <= 5'h00;
    end else begin
      ph_r <= (ph_r >= (slow ? 5'h17 : 5'h0B)) ? 5'h00 : ph_r + 5'h01;
    end
  end
  assign cycle_start = ph_r == 5'h00; // One clock wide boundary
  assign pwm_high = ph_r < (slow ? 5'h0C : 5'h06); // High side asked in first half
  assign enable_in = !drop_en; // Low then high again clears a latch
endmodule
`default_nettype wire

/* verif/hbf_fault_props.sv */
// Port assertions for the half-bridge fault reporter
`timescale 1ns/100ps
`default_nettype none
module hbf_fault_props
  import hbf_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic supply_ok, // Logic supply good pin
  input wire logic high_side_switch, // High-side gate
  input wire logic low_side_switch, // Low-side gate
  input wire logic temp_fault_at_supply, // Output forced to supply
  input wire logic fault_latched, // Any fault latched
  input wire logic signed [TEMP_W-1:0] tj_degc, // Junction temperature
  input wire logic [MV_W-1:0] temp_fault_mv, // Temperature level
  input wire logic [1:0] pwm_term // Termination code
);
  logic [3:0] quiet_cnt_r; // Latched cycles with no code shown yet, saturating

  // Counts the quiet part of the code delay; a long repetition would unroll badly
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      quiet_cnt_r <= 4'h0;
    end else if (!fault_latched) begin
      quiet_cnt_r <= 4'h0;
    end else if (pwm_term == 2'h0 && quiet_cnt_r != 4'hF) begin
      quiet_cnt_r <= quiet_cnt_r + 4'h1;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Code stays quiet through the whole indication delay of ten cycles
  sequence s_quiet; ##10 quiet_cnt_r == 4'hA; endsequence
  // Temperature held long enough for the registered level to follow
  sequence s_settled; $stable(tj_degc) [*3] ##0 !temp_fault_at_supply; endsequence
  property p_supply; fault_latched |-> temp_fault_at_supply && temp_fault_mv == 12'h000; endproperty
  a_supply: assert property (p_supply) else $error("output not at supply");
  property p_delay; $rose(fault_latched) |-> s_quiet ##0 pwm_term != 2'h0; endproperty
  a_delay: assert property (p_delay) else $error("code timing wrong");
  property p_hs_off; fault_latched |-> !high_side_switch; endproperty
  a_hs_off: assert property (p_hs_off) else $error("high side on in fault");
  property p_ls_stay;
    fault_latched && $past(fault_latched) && !low_side_switch |=> !low_side_switch || !fault_latched;
  endproperty
  a_ls_stay: assert property (p_ls_stay) else $error("low side back on");
  property p_short_ls; pwm_term == HBF_TERM_PU1K |-> !low_side_switch; endproperty
  a_short_ls: assert property (p_short_ls) else $error("low side on in short");
  property p_release; $fell(supply_ok) |-> ##[1:5] !fault_latched; endproperty
  a_release: assert property (p_release) else $error("latch not released");
  property p_keep;
    fault_latched && $past(fault_latched) && $past(pwm_term) != 2'h0 |-> $stable(pwm_term);
  endproperty
  a_keep: assert property (p_keep) else $error("fault code changed");
  property p_temp;
    s_settled ##0 temp_fault_mv != 12'h000 |-> temp_fault_mv == 12'(800 + 8 * (int'(tj_degc) - 25));
  endproperty
  a_temp: assert property (p_temp) else $error("temperature level wrong");
endmodule
bind hbf_fault_reporter hbf_fault_props hbf_fault_props_i (.core_clk, .resetn, .supply_ok,
  .high_side_switch, .low_side_switch, .temp_fault_at_supply, .fault_latched, .tj_degc,
  .temp_fault_mv, .pwm_term);
`default_nettype wire

/* verif/hbf_fault_reporter_test.sv */
// Self-checking bench for the half-bridge fault reporter
`timescale 1ns/100ps
`default_nettype none
module hbf_fault_reporter_test;
  import hbf_pkg::*;
  logic core_clk = 0, resetn = 0, slow = 1, drop_en = 0, supply_ok = 1, hs_ilim = 0;
  logic ls_valley_lim = 0, zero_current_detect = 0, sw_short = 0;
  logic signed [TEMP_W-1:0] tj_degc = 9'sh019;
  wire logic enable_in, pwm_high, cycle_start, high_side_switch, low_side_switch;
  wire logic temp_fault_at_supply, fault_latched;
  wire logic [MV_W-1:0] temp_fault_mv;
  wire logic [1:0] pwm_term;
  int errors = 0, total_checks = 0, ticks = 0, i;
  int code_q[$] = '{1, 2, 3}; // Expected code for limit, heat, short
  hbf_ctrl_model hbf_ctrl_model_i (.core_clk, .resetn, .slow, .drop_en, .enable_in, .pwm_high,
    .cycle_start);
  hbf_fault_reporter hbf_fault_reporter_i (.core_clk, .resetn, .enable_in, .supply_ok,
    .pwm_high, .cycle_start, .hs_ilim, .ls_valley_lim, .zero_current_detect, .sw_short,
    .tj_degc, .high_side_switch, .low_side_switch, .temp_fault_mv, .temp_fault_at_supply,
    .pwm_term, .fault_latched);
  initial forever #10 core_clk = ~core_clk;
  // Hang guard, well above the several hundred cycles needed
  always @(posedge core_clk) begin
    ticks++;
    if (ticks == 20000) begin
      errors++;
      give_verdict;
    end
  end
  task cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Await the latch, then the code once its delay is over
  task fault_code(input int k);
    for (i = 0; i < 400 && fault_latched !== 1'b1; i++) cyc(1);
    chk("at_supply", {fault_latched, temp_fault_at_supply}, 12'h003);
    chk("flt_mv", temp_fault_mv, 12'h000);
    cyc(11);
    chk("term", pwm_term, 12'(code_q[k]));
  endtask
  task toggle_en;
    drop_en = 1;
    cyc(5);
    drop_en = 0;
    cyc(6);
    chk("cleared", {fault_latched, pwm_term}, 12'h000);
  endtask
  // Limit from just after a boundary into mid n-th cycle; ending early keeps the next cycle clean.
  // Raised on the boundary's own clock, it would be charged to the cycle before as well.
  task burst(input int n);
    @(posedge cycle_start);
    cyc(2);
    hs_ilim = 1;
    cyc(5);
    chk("hs_blank", high_side_switch, 12'h000);
    repeat (n - 1) @(posedge cycle_start);
    cyc(6);
    hs_ilim = 0;
  endtask
  initial begin
    void'($urandom(64374));
    cyc(2);
    resetn = 1;
    cyc(6);
    for (i = 0; i < 6; i++) begin
      tj_degc = 9'($urandom_range(150));
      cyc(6);
      chk("temp_mv", temp_fault_mv, 12'(800 + 8 * (int'(tj_degc) - 25)));
    end
    burst(7);
    @(posedge cycle_start);
    burst(7);
    chk("no_trip", fault_latched, 12'h000);
    burst(1);
    fault_code(0);
    toggle_en;
    slow = 0;
    tj_degc = 9'sh0A0;
    cyc(8);
    chk("no_heat", fault_latched, 12'h000);
    tj_degc = 9'sh0A1;
    fault_code(1);
    chk("ls_hold", low_side_switch, 12'h001);
    sw_short = 1;
    cyc(12);
    chk("kept", pwm_term, 12'h002);
    zero_current_detect = 1;
    cyc(5);
    chk("ls_zero", low_side_switch, 12'h000);
    {sw_short, zero_current_detect, supply_ok} = 3'h0;
    tj_degc = 9'sh019;
    cyc(6);
    chk("supply_rel", fault_latched, 12'h000);
    supply_ok = 1;
    for (i = 0; i < 40; i++) begin
      ls_valley_lim = 1'($urandom);
      cyc(1);
    end
    chk("valley", fault_latched, 12'h000);
    sw_short = 1;
    fault_code(2);
    chk("ls_short", low_side_switch, 12'h000);
    sw_short = 0;
    toggle_en;
    give_verdict;
  end
endmodule
`default_nettype wire
